/* hdl/clock_monitor.sv */
// Clock monitor: flags a missing E clock edge within a fixed delay.
`timescale 1ns/1ps
module clock_monitor
  import wdog_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic enable,
  input  wire logic stop_req,
  // Monitored clock
  input  wire logic e_clk,
  // Result
  output logic      fail
);

  logic [8:0] gap_r;
  logic       e_d_r;
  logic       e_edge;

  assign e_edge = e_clk != e_d_r;
  assign fail = enable && !e_edge && ((gap_r == 9'(CM_DELAY_CYC - 1)) || stop_req);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      e_d_r <= 1'b0;
    else
      e_d_r <= e_clk;
  end

  // The delay counter stands in for the RC timer, so it runs off pclk rather than the E clock.
  // detection threshold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_r <= 9'd0;
    else if (!enable || e_edge)
      gap_r <= 9'd0;
    else if (gap_r != 9'(CM_DELAY_CYC - 1))
      gap_r <= gap_r + 9'd1;
  end

  a_edge_no_fail: assert property (@(posedge pclk) disable iff (!presetn)
    e_edge |-> !fail)
    else $error("monitor failed on a clock edge");

  a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |-> !fail ##1 (gap_r == 9'd0))
    else $error("monitor active while disabled");

endmodule

/* hdl/reset_control.sv */
// Watchdog, clock monitor, write-once configuration and reset vector selection behind APB.
`timescale 1ns/1ps
module reset_control
  import wdog_pkg::*;
#(
  parameter int PRESCALE_DIV = WD_PRESCALE
)(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip state
  input  wire logic        special_mode,
  input  wire logic        e_clk,
  input  wire logic        stop_req,
  // Reset and restart
  output logic             sys_reset,
  output logic [15:0]      reset_vector,
  output logic [15:0]      fetch_addr,
  output logic             fetch_valid,
  output logic             ccr_x_mask,
  output logic             ccr_i_mask,
  output logic             ccr_stop_disable,
  // Configuration outputs
  output logic             irq_edge_select,
  output logic             osc_startup_delay,
  output logic             clock_monitor_enable,
  output logic             rom_enable
);

  // ****************************************************************
  // Internal reset, mode capture and E clock timing
  // ****************************************************************

  logic            soft_rst_r;
  logic            init_done_r;
  logic            special_r;
  logic            e_d_r;
  logic [6:0]      e_cnt_r;
  logic            e_tick;
  logic            window_open;
  cause_type       cause_r;
  logic            wd_timeout;
  logic            wd_armed;
  logic            wd_active;
  logic            wd_fire;
  logic            cm_fire;

  assign e_tick      = e_clk && !e_d_r;
  assign window_open = e_cnt_r < 7'(WRITE_WINDOW_E);

  // A fired reset reinitialises the block the same way presetn does, but keeps the cause.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= wd_fire || cm_fire;
  end

  // The mode strap is caught on the first edge after either reset, never by the reset itself.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_done_r <= 1'b0;
      special_r   <= 1'b0;
    end
    else if (soft_rst_r)
      init_done_r <= 1'b0;
    else if (!init_done_r)
    begin
      init_done_r <= 1'b1;
      special_r   <= special_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      e_d_r <= 1'b0;
    else
      e_d_r <= e_clk;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      e_cnt_r <= 7'd0;
    else if (soft_rst_r)
      e_cnt_r <= 7'd0;
    else if (e_tick && window_open)
      e_cnt_r <= e_cnt_r + 7'd1;
  end

  // Clock monitor outranks the watchdog when both fire together.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_r <= CAUSE_POR;
    else if (cm_fire)
      cause_r <= CAUSE_CLKMON;
    else if (wd_fire)
      cause_r <= CAUSE_WDOG;
  end

  // ****************************************************************
  // APB register access
  // ****************************************************************

  logic            wr_en;
  logic            rd_setup;
  logic            mapped;
  logic            once_ok;
  logic            opt_locked_r;
  logic            cfg_locked_r;
  logic            irq_edge_select_r;
  logic            dly_r;
  logic            cme_r;
  logic [1:0]      rate_r;
  logic            wd_dis_r;
  logic            rom_en_r;
  logic            dis_rst_r;
  logic [7:0]      rdata_nxt;
  logic [31:0]     prdata_r;
  logic            opt_wr;
  logic            cfg_wr;

  assign mapped   = (paddr == byte_addr(IDX_OPTION)) || (paddr == byte_addr(IDX_SERVICE)) ||
                    (paddr == byte_addr(IDX_TEST)) || (paddr == byte_addr(IDX_CONFIG)) ||
                    (paddr == byte_addr(IDX_STATUS));
  assign wr_en    = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_r;
  assign opt_wr   = wr_en && (paddr == byte_addr(IDX_OPTION));
  assign cfg_wr   = wr_en && (paddr == byte_addr(IDX_CONFIG));
  assign once_ok  = special_r || window_open;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      opt_locked_r <= 1'b0;
    else if (soft_rst_r)
      opt_locked_r <= 1'b0;
    else if (opt_wr && !special_r)
      opt_locked_r <= 1'b1;
  end

  // rates cleared
  // The internal reset is taken on the clock so that the asynchronous branch
  // only ever loads constants; mixing the two in one condition would not map
  // onto a plain reset flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_edge_select_r <= OPTION_RST[OPT_IRQ_EDGE_SELECT];
      dly_r  <= OPTION_RST[OPT_DLY];
      rate_r <= OPTION_RST[1:0];
    end
    else if (soft_rst_r)
    begin
      irq_edge_select_r <= OPTION_RST[OPT_IRQ_EDGE_SELECT];
      dly_r  <= OPTION_RST[OPT_DLY];
      rate_r <= OPTION_RST[1:0];
    end
    else if (opt_wr && once_ok && !opt_locked_r)
    begin
      irq_edge_select_r <= pwdata[OPT_IRQ_EDGE_SELECT];
      dly_r  <= pwdata[OPT_DLY];
      rate_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cme_r <= OPTION_RST[OPT_CME];
    else if (soft_rst_r)
      cme_r <= OPTION_RST[OPT_CME];
    else if (opt_wr)
      cme_r <= pwdata[OPT_CME];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_locked_r <= 1'b0;
    else if (soft_rst_r)
      cfg_locked_r <= 1'b0;
    else if (cfg_wr && !special_r)
      cfg_locked_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_dis_r <= CONFIG_RST[CFG_WD_DIS];
      rom_en_r <= CONFIG_RST[CFG_ROM_EN];
    end
    else if (soft_rst_r)
    begin
      wd_dis_r <= CONFIG_RST[CFG_WD_DIS];
      rom_en_r <= CONFIG_RST[CFG_ROM_EN];
    end
    else if (!init_done_r)
      wd_dis_r <= special_mode;
    else if (cfg_wr && once_ok && !cfg_locked_r)
    begin
      wd_dis_r <= pwdata[CFG_WD_DIS];
      rom_en_r <= pwdata[CFG_ROM_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dis_rst_r <= 1'b0;
    else if (soft_rst_r)
      dis_rst_r <= 1'b0;
    else if (!init_done_r)
      dis_rst_r <= special_mode;
    else if (wr_en && special_r && (paddr == byte_addr(IDX_TEST)))
      dis_rst_r <= pwdata[TST_DIS_RST];
  end

  always_comb
  begin
    rdata_nxt = 8'h00;
    case (paddr)
      byte_addr(IDX_OPTION): rdata_nxt = {2'b00, irq_edge_select_r, dly_r, cme_r, 1'b0, rate_r};
      byte_addr(IDX_CONFIG): rdata_nxt = {5'b00000, wd_dis_r, rom_en_r, 1'b0};
      byte_addr(IDX_TEST):   rdata_nxt = {7'b0000000, dis_rst_r};
      byte_addr(IDX_STATUS): rdata_nxt = {3'b000, wd_armed, special_r, !window_open, cause_r};
      default:               rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (rd_setup)
      prdata_r <= {24'h00_0000, rdata_nxt};
  end

  // ****************************************************************
  // Watchdog and clock monitor
  // ****************************************************************

  assign wd_active = init_done_r && !wd_dis_r && !dis_rst_r;
  assign wd_fire   = wd_timeout && wd_active && !soft_rst_r;

  wdog_timer #(
    .PRESCALE_DIV (PRESCALE_DIV)
  ) u_wdog (
    .pclk     (pclk),
    .presetn  (presetn),
    .soft_clr (soft_rst_r),
    .e_tick   (e_tick),
    .rate_sel (rate_r),
    .arm_wr   (wr_en && (paddr == byte_addr(IDX_SERVICE)) && (pwdata[7:0] == ARM_KEY)),
    .clear_wr (wr_en && (paddr == byte_addr(IDX_SERVICE)) && (pwdata[7:0] == CLEAR_KEY)),
    .timeout  (wd_timeout),
    .armed    (wd_armed)
  );

  clock_monitor u_cmon (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (cme_r && !soft_rst_r),
    .stop_req (stop_req),
    .e_clk    (e_clk),
    .fail     (cm_fire)
  );

  // ****************************************************************
  // Restart vector fetch
  // ****************************************************************

  fetch_state_type fetch_state_r;
  logic [15:0]     vector_r;
  logic [15:0]     fetch_addr_r;
  logic            ccr_masks_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_state_r <= FETCH_INIT;
      vector_r      <= VEC_POR_NORM;
      fetch_addr_r  <= 16'h0000;
    end
    else if (soft_rst_r)
      fetch_state_r <= FETCH_INIT;
    else
    begin
      case (fetch_state_r)
        FETCH_INIT:
        begin
          vector_r      <= vector_of(cause_r, special_mode);
          fetch_addr_r  <= vector_of(cause_r, special_mode);
          fetch_state_r <= FETCH_HI;
        end
        FETCH_HI:
        begin
          fetch_addr_r  <= vector_r + 16'h0001;
          fetch_state_r <= FETCH_LO;
        end
        FETCH_LO:   fetch_state_r <= FETCH_LOAD;
        FETCH_LOAD: fetch_state_r <= FETCH_RUN;
        FETCH_RUN:  fetch_state_r <= FETCH_RUN;
        default:    fetch_state_r <= FETCH_INIT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ccr_masks_r <= 1'b1;
    else
      ccr_masks_r <= 1'b1;
  end

  assign reset_vector         = vector_r;
  assign fetch_addr           = fetch_addr_r;
  assign fetch_valid          = (fetch_state_r == FETCH_HI) || (fetch_state_r == FETCH_LO);
  assign ccr_x_mask           = ccr_masks_r;
  assign ccr_i_mask           = ccr_masks_r;
  assign ccr_stop_disable     = ccr_masks_r;
  assign sys_reset            = soft_rst_r;
  assign irq_edge_select      = irq_edge_select_r;
  assign osc_startup_delay    = dly_r;
  assign clock_monitor_enable = cme_r;
  assign rom_enable           = rom_en_r;

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_rate_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (opt_locked_r && !special_r && !soft_rst_r) |=> $stable(rate_r))
    else $error("rate bits changed after lock");

  a_fire_resets: assert property (@(posedge pclk) disable iff (!presetn)
    wd_fire |=> sys_reset ##1 (cause_r == CAUSE_WDOG || cause_r == CAUSE_CLKMON) && (rate_r == 2'd0))
    else $error("time-out did not reset");

  a_disabled_silent: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_dis_r || dis_rst_r) |-> !wd_fire)
    else $error("disabled watchdog fired");

  a_cme_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    cm_fire |=> ##1 !cme_r && (cause_r == CAUSE_CLKMON))
    else $error("monitor enable kept after reset");

  a_vector_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (fetch_state_r == FETCH_INIT && !soft_rst_r) |=> fetch_valid && (fetch_addr == reset_vector) ##1
      fetch_valid && (fetch_addr == reset_vector + 16'h0001) ##1 !fetch_valid)
    else $error("vector fetch sequence wrong");

  c_watchdog_reset: cover property (@(posedge pclk) disable iff (!presetn) wd_fire);
  c_monitor_reset:  cover property (@(posedge pclk) disable iff (!presetn) cm_fire);
  c_service_clear:  cover property (@(posedge pclk) disable iff (!presetn)
    wd_armed ##[1:20] !wd_armed && !sys_reset);

endmodule

/* hdl/wdog_pkg.sv */
// Constants and types shared by the watchdog, clock monitor and reset vector logic.
package wdog_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_STATUS  = 8'h30;
  localparam logic [7:0] IDX_OPTION  = 8'h39;
  localparam logic [7:0] IDX_SERVICE = 8'h3a;
  localparam logic [7:0] IDX_TEST    = 8'h3e;
  localparam logic [7:0] IDX_CONFIG  = 8'h3f;

  // Field positions.
  localparam int OPT_IRQ_EDGE_SELECT     = 5;
  localparam int OPT_DLY      = 4;
  localparam int OPT_CME      = 3;
  localparam int CFG_WD_DIS   = 2;
  localparam int CFG_ROM_EN   = 1;
  localparam int TST_DIS_RST  = 0;

  // Values after reset.
  localparam logic [7:0] OPTION_RST = 8'h10;
  localparam logic [7:0] CONFIG_RST = 8'h02;

  // Service keys.
  localparam logic [7:0] ARM_KEY   = 8'h55;
  localparam logic [7:0] CLEAR_KEY = 8'haa;

  // Timing.
  localparam int WD_PRESCALE    = 32768;
  localparam int WRITE_WINDOW_E = 64;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CM_DELAY_NS    = 20000;
  localparam int CM_DELAY_CYC   = CM_DELAY_NS / CLK_PERIOD_NS;

  // Reset vectors.
  localparam logic [15:0] VEC_POR_NORM = 16'hfffe;
  localparam logic [15:0] VEC_CM_NORM  = 16'hfffc;
  localparam logic [15:0] VEC_WD_NORM  = 16'hfffa;
  localparam logic [15:0] VEC_POR_SPEC = 16'hbffe;
  localparam logic [15:0] VEC_CM_SPEC  = 16'hbffc;
  localparam logic [15:0] VEC_WD_SPEC  = 16'hbffa;

  typedef enum logic [1:0] {CAUSE_POR, CAUSE_CLKMON, CAUSE_WDOG} cause_type;
  typedef enum logic [2:0] {FETCH_INIT, FETCH_HI, FETCH_LO, FETCH_LOAD, FETCH_RUN} fetch_state_type;

  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  function automatic logic [5:0] scale_last(input logic [1:0] rate);
    case (rate)
      2'd0:    return 6'd0;
      2'd1:    return 6'd3;
      2'd2:    return 6'd15;
      default: return 6'd63;
    endcase
  endfunction

  function automatic logic [15:0] vector_of(input cause_type cause, input logic special);
    case (cause)
      CAUSE_CLKMON: return special ? VEC_CM_SPEC : VEC_CM_NORM;
      CAUSE_WDOG:   return special ? VEC_WD_SPEC : VEC_WD_NORM;
      default:      return special ? VEC_POR_SPEC : VEC_POR_NORM;
    endcase
  endfunction

endpackage

/* hdl/wdog_timer.sv */
// Free-running watchdog counter with fixed prescaler, rate scaler and arm/clear service.
`timescale 1ns/1ps
module wdog_timer
  import wdog_pkg::*;
#(
  parameter int PRESCALE_DIV = WD_PRESCALE
)(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       soft_clr,
  // Count control
  input  wire logic       e_tick,
  input  wire logic [1:0] rate_sel,
  // Service writes
  input  wire logic       arm_wr,
  input  wire logic       clear_wr,
  // Status
  output logic            timeout,
  output logic            armed
);

  logic [15:0] pre_r;
  logic [5:0]  scl_r;
  logic        armed_r;
  logic        pre_wrap;
  logic        clear_ok;

  assign pre_wrap = e_tick && (pre_r == 16'(PRESCALE_DIV - 1));
  assign clear_ok = clear_wr && armed_r;
  assign timeout  = pre_wrap && (scl_r == scale_last(rate_sel));
  assign armed    = armed_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= 16'h0000;
    else if (soft_clr || clear_ok)
      pre_r <= 16'h0000;
    else if (e_tick)
      pre_r <= pre_wrap ? 16'h0000 : pre_r + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scl_r <= 6'd0;
    else if (soft_clr || clear_ok || timeout)
      scl_r <= 6'd0;
    else if (pre_wrap)
      scl_r <= scl_r + 6'd1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_r <= 1'b0;
    else if (soft_clr || clear_ok)
      armed_r <= 1'b0;
    else if (arm_wr)
      armed_r <= 1'b1;
  end

  a_clear_restarts: assert property (@(posedge pclk) disable iff (!presetn)
    clear_ok |=> (pre_r == 16'h0000) && (scl_r == 6'd0) && !armed_r)
    else $error("watchdog not restarted by clear");

  a_unarmed_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clear_wr && !armed_r && !soft_clr && !e_tick) |=> (pre_r == $past(pre_r)))
    else $error("counter cleared without arm");

endmodule

/* verif/test_reset_control.sv */
// Self-checking bench for the watchdog, clock monitor and reset vector logic.
`timescale 1ns/1ps
module test_reset_control;
  import wdog_pkg::*;
  localparam int         DIV   = 8;
  localparam logic [7:0] A_OPT = 8'he4;
  localparam logic [7:0] A_SRV = 8'he8;
  localparam logic [7:0] A_TST = 8'hf8;
  localparam logic [7:0] A_CFG = 8'hfc;
  localparam logic [7:0] A_STS = 8'hc0;
  localparam logic [7:0] A_BAD = 8'h04;
  logic        pclk, presetn, psel, penable, pwrite, special_mode, e_clk, stop_req, e_run, berr;
  logic        pready, pslverr, sys_reset, fetch_valid, ccr_x_mask, ccr_i_mask, ccr_stop_disable;
  logic        irq_edge_select, osc_startup_delay, clock_monitor_enable, rom_enable;
  logic [7:0]  paddr;
  logic [15:0] reset_vector, fetch_addr;
  logic [31:0] pwdata, prdata, rd, opt_m;
  int          fails, num_checks, cyc, rst_cnt, cap, r, tcyc;

  reset_control #(.PRESCALE_DIV(DIV)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .e_clk(e_clk), .stop_req(stop_req), .sys_reset(sys_reset),
    .reset_vector(reset_vector), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .ccr_x_mask(ccr_x_mask), .ccr_i_mask(ccr_i_mask), .ccr_stop_disable(ccr_stop_disable),
    .irq_edge_select(irq_edge_select), .osc_startup_delay(osc_startup_delay),
    .clock_monitor_enable(clock_monitor_enable), .rom_enable(rom_enable));

  always #25 pclk = ~pclk;

  // The E clock runs at a quarter of the bus clock, so one E tick is four cycles.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (e_run && cyc[0])
      e_clk <= ~e_clk;
    if (sys_reset === 1'b1)
      rst_cnt <= rst_cnt + 1;
    if (cyc > 20000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected register at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    berr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for the reset pulse within lo..hi cycles, then checks the restart fetch.
  task automatic expect_rst(input int lo, input int hi, input logic [15:0] vec);
    int n;
    int k;
    n = 0;
    while (sys_reset !== 1'b1 && n <= hi)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk_out(16'(n >= lo && n <= hi), 16'h0001);
    k = 0;
    while (fetch_valid !== 1'b1 && k < 5)
    begin
      @(posedge pclk);
      #1;
      k++;
    end
    chk_out(fetch_addr, vec);
    chk_out(reset_vector, vec);
  endtask

  task automatic do_reset(input logic mode);
    presetn <= 1'b0;
    special_mode <= mode;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    special_mode = 0; e_clk = 0; stop_req = 0; e_run = 1; cyc = 0; rst_cnt = 0;
    void'($urandom(32'hebcadfdf));
    do_reset(1'b0);
    chk_out(reset_vector, VEC_POR_NORM);
    chk_out({ccr_x_mask, ccr_i_mask, ccr_stop_disable}, 16'h0007);
    apb(0, A_OPT, 0);
    chk_reg(rd, 32'h0000_0010);
    apb(0, A_CFG, 0);
    chk_reg(rd, 32'h0000_0002);
    apb(0, A_BAD, 0);
    chk_out(16'(berr), 16'h0001);
    r = 1 + $urandom % 3;
    tcyc = DIV * (1 << (2 * r)) * 4;
    opt_m = 32'h20 | r;
    apb(1, A_OPT, opt_m);
    apb(1, A_OPT, 32'h0000_001b);
    opt_m = opt_m | 32'h08;
    apb(0, A_OPT, 0);
    chk_reg(rd, opt_m);
    chk_out({irq_edge_select, osc_startup_delay, clock_monitor_enable}, 16'h0005);
    apb(1, A_OPT, 0);
    apb(0, A_OPT, 0);
    chk_reg(rd, opt_m & 32'hf7);
    cap = rst_cnt;
    repeat (4)
    begin
      apb(1, A_SRV, ARM_KEY);
      repeat ($urandom % (tcyc / 4)) @(posedge pclk);
      apb(0, A_OPT, 0);
      apb(1, A_SRV, CLEAR_KEY);
    end
    chk_out(16'(rst_cnt - cap), 16'h0000);
    expect_rst(tcyc - 8, tcyc + 8, VEC_WD_NORM);
    apb(0, A_STS, 0);
    chk_reg(rd & 32'h3, 32'h0000_0002);
    apb(1, A_SRV, CLEAR_KEY);
    expect_rst(0, DIV * 4 + 8, VEC_WD_NORM);
    apb(1, A_CFG, 32'h0000_0006);
    apb(1, A_CFG, 32'h0000_0002);
    apb(0, A_CFG, 0);
    chk_reg(rd, 32'h0000_0006);
    cap = rst_cnt;
    repeat (100) @(posedge pclk);
    chk_out(16'(rst_cnt - cap), 16'h0000);
    apb(1, A_OPT, 32'h0000_0008);
    e_run = 0;
    expect_rst(390, 410, VEC_CM_NORM);
    e_run = 1;
    apb(1, A_CFG, 32'h0000_0006);
    apb(1, A_OPT, 32'h0000_0008);
    stop_req <= 1'b1;
    expect_rst(0, 6, VEC_CM_NORM);
    stop_req <= 1'b0;
    chk_out(16'(clock_monitor_enable), 16'h0000);
    cap = rst_cnt;
    stop_req <= 1'b1;
    repeat (10) @(posedge pclk);
    stop_req <= 1'b0;
    chk_out(16'(rst_cnt - cap), 16'h0000);
    do_reset(1'b1);
    chk_out(reset_vector, VEC_POR_SPEC);
    apb(0, A_CFG, 0);
    chk_reg(rd, 32'h0000_0006);
    apb(0, A_TST, 0);
    chk_reg(rd & 32'h1, 32'h0000_0001);
    apb(1, A_CFG, 32'h0000_0002);
    apb(1, A_CFG, 32'h0000_0006);
    apb(1, A_CFG, 32'h0000_0002);
    apb(0, A_CFG, 0);
    chk_reg(rd, 32'h0000_0002);
    cap = rst_cnt;
    repeat (60) @(posedge pclk);
    chk_out(16'(rst_cnt - cap), 16'h0000);
    apb(1, A_TST, 0);
    expect_rst(0, DIV * 4 + 8, VEC_WD_SPEC);
    complete_run();
  end
endmodule
